// >>> ostt_down_counter.sv
// module: loadable down counter, WIDTH bits (2 to 32, default 32)
`timescale 1ns/100ps
module ostt_down_counter
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // control
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_value_i,
    input wire logic dec_i,
    // state
    output logic [WIDTH-1:0] count_o
);
    import ostt_pkg::*;

    if (WIDTH < 2 || WIDTH > 32)
    begin
        $error("ostt_down_counter: WIDTH must be 2..32");
    end

    // clear beats load beats decrement
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_o <= OSTT_COUNT_RST[WIDTH-1:0];
        end
        else if (clear_i)
        begin
            count_o <= '0;
        end
        else if (load_i)
        begin
            count_o <= load_value_i;
        end
        else if (dec_i && count_o != '0)
        begin
            count_o <= count_o - WIDTH'(1);
        end
    end
endmodule

// >>> ostt_pkg.sv
// package: register map, field positions and carriers of the os tick timer
package ostt_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OSTT_OFF_COUNT = 8'h00;
    localparam logic [7:0] OSTT_OFF_RELOAD = 8'h04;
    localparam logic [7:0] OSTT_OFF_CTRL = 8'h08;

    // ----------------------------------------
    // control field positions and reset values
    // ----------------------------------------
    localparam int OSTT_BIT_ENABLE = 0;
    localparam int OSTT_BIT_RELOAD = 1;
    localparam int OSTT_BIT_START = 2;
    localparam int OSTT_BIT_EXT_HALT_EN = 3;
    localparam int OSTT_BIT_FW_HALT = 4;
    localparam logic [4:0] OSTT_CTRL_RST = 5'h00;
    localparam logic [31:0] OSTT_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] OSTT_RELOAD_RST = 32'h0000_0000;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic fw_halt;
        logic ext_halt_en;
        logic start;
        logic auto_reload;
        logic enable;
    } ostt_ctrl_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ostt_bus_req_t;

    typedef enum logic [1:0] {
        OSTT_IDLE = 2'b00,
        OSTT_RUN = 2'b01,
        OSTT_DONE = 2'b11
    } ostt_state_t;

endpackage

// >>> ostt_sync.sv
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module ostt_sync
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // data
    input wire logic async_i,
    output logic sync_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // only a level that stood two samples counts
            if (s2_q == s3_q)
            begin
                sync_o <= s3_q;
            end
        end
    end
endmodule

// >>> ostt_top.sv
// module: os tick timer control, registers and count sequencing
//
// Notes on behaviour
// (R01) firmware halt bit 4 freezes the counter
// (R02) bit 3 permits external halt input
// (R03) start bit loads reload value, counts down; the code loads only when the same write also sets enable bit 0
// (R04) clearing start zeroes count, no interrupt
// (R05) one-shot clears start on expiry
// (R06) reload mode self-clears start only with a zero reload value
// (R07) reload and count both zero clear start
// (R08) reload bit 0: stop in done state
// (R09) reload bit 1: restart from reload value
// (R10) enable 0 stops timer, lowest power
// (R11) enable falling edge restores all defaults
// (R12) registers always accessible, even when disabled
// (R13) interrupt on count step from one, to zero or to the reload value
// (R14) external halt high holds, low resumes
// (R15) zero reload: finish, then clear start
// (R16) running reload write waits for reload
// (R17) running counter decrements once per tick
// (R18) halt freezes count, start bit unchanged
`timescale 1ns/100ps
module ostt_top
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // register port
    input wire ostt_pkg::ostt_bus_req_t bus_req_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_ack_o,
    // timer side
    input wire logic ext_halt_i,
    output logic [WIDTH-1:0] current_tick_count_o,
    output logic [WIDTH-1:0] reload_value_o,
    output logic irq_o,
    output logic timer_clk_en_o
);
    import ostt_pkg::*;

    // the count and the register readback share one 32-bit word
    if (WIDTH < 2 || WIDTH > 32)
    begin
        $error("ostt_top: WIDTH must be 2..32");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    ostt_ctrl_t ctrl_q;
    ostt_state_t state_q;
    logic [WIDTH-1:0] reload_q;
    logic [WIDTH-1:0] count;
    logic ext_halt_s;
    logic enable_fall;
    logic wr_ctrl;
    logic wr_reload;
    logic start_set;
    logic start_clr;
    logic halted;
    logic running;
    logic expire;
    logic cnt_clear;
    logic cnt_load;
    logic [31:0] wdata;
    logic rd_req;
    logic wr_req;
    logic sel_count;
    logic sel_reload;
    logic sel_ctrl;
    logic stop_at_end;
    logic zero_idle;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    always_comb
    begin
        sel_count = 1'b0;
        sel_reload = 1'b0;
        sel_ctrl = 1'b0;
        if (bus_req_i.addr == OSTT_OFF_COUNT)
        begin
            sel_count = 1'b1;
        end
        else if (bus_req_i.addr == OSTT_OFF_RELOAD)
        begin
            sel_reload = 1'b1;
        end
        else if (bus_req_i.addr == OSTT_OFF_CTRL)
        begin
            sel_ctrl = 1'b1;
        end
    end

    assign wdata = bus_req_i.wdata;
    assign rd_req = bus_req_i.req && !bus_req_i.wr;
    assign wr_req = bus_req_i.req && bus_req_i.wr;
    assign wr_ctrl = wr_req && sel_ctrl;
    assign wr_reload = wr_req && sel_reload;
    assign enable_fall = wr_ctrl && ctrl_q.enable && !wdata[OSTT_BIT_ENABLE]; // R11
    assign start_set = wr_ctrl && !ctrl_q.start && wdata[OSTT_BIT_START]; // R03
    assign start_clr = wr_ctrl && ctrl_q.start && !wdata[OSTT_BIT_START]; // R04

    // ----------------------------------------
    // halt input and gating
    // ----------------------------------------
    ostt_sync u_halt_sync
    (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(ext_halt_i),
        .sync_o(ext_halt_s)
    );

    // either halt source freezes the count; start is left alone
    assign halted = ctrl_q.fw_halt || (ctrl_q.ext_halt_en && ext_halt_s); // R01 R02 R14 R18
    assign running = ctrl_q.enable && ctrl_q.start && state_q == OSTT_RUN && !halted; // R10 R17
    assign expire = running && count == WIDTH'(1); // R13
    // a count that ends in one-shot, or with no reload value to take, drops start
    assign stop_at_end = expire && (!ctrl_q.auto_reload || reload_q == '0); // R05 R06 R15
    assign zero_idle = ctrl_q.start && reload_q == '0 && count == '0; // R07

    // ----------------------------------------
    // counter
    // ----------------------------------------
    assign cnt_clear = enable_fall || start_clr; // R04 R11
    // a reload write never touches the count in progress; it is used at the next load
    assign cnt_load = (start_set && wdata[OSTT_BIT_ENABLE]) || (expire && ctrl_q.auto_reload); // R03 R09 R16

    ostt_down_counter #(.WIDTH(WIDTH)) u_count
    (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clear_i(cnt_clear),
        .load_i(cnt_load),
        .load_value_i(reload_q),
        // one-shot steps from one to zero on the last tick; in reload mode the load wins
        .dec_i(running), // R17 R13
        .count_o(count)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // writes are taken whatever the enable bit says
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reload_q <= OSTT_RELOAD_RST[WIDTH-1:0];
        end
        else if (enable_fall)
        begin
            reload_q <= OSTT_RELOAD_RST[WIDTH-1:0]; // R11
        end
        else if (wr_reload)
        begin
            reload_q <= wdata[WIDTH-1:0]; // R12
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q <= OSTT_CTRL_RST;
        end
        else if (enable_fall)
        begin
            ctrl_q <= OSTT_CTRL_RST; // R11
        end
        else if (wr_ctrl)
        begin
            ctrl_q.fw_halt <= wdata[OSTT_BIT_FW_HALT]; // R01
            ctrl_q.ext_halt_en <= wdata[OSTT_BIT_EXT_HALT_EN]; // R02
            ctrl_q.auto_reload <= wdata[OSTT_BIT_RELOAD]; // R08 R09
            ctrl_q.enable <= wdata[OSTT_BIT_ENABLE]; // R10 R12
            // starting with a zero reload value drops straight back
            ctrl_q.start <= wdata[OSTT_BIT_START] && !(start_set && reload_q == '0); // R15
        end
        else if (zero_idle)
        begin
            ctrl_q.start <= 1'b0; // R07 R15
        end
        else if (stop_at_end)
        begin
            ctrl_q.start <= 1'b0; // R05 R06 R15
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= OSTT_IDLE;
        end
        else if (cnt_clear)
        begin
            state_q <= OSTT_IDLE; // R04 R11
        end
        else
        begin
            case (state_q)
                OSTT_IDLE:
                begin
                    if (cnt_load)
                    begin
                        state_q <= OSTT_RUN; // R03
                    end
                end
                OSTT_RUN:
                begin
                    if (stop_at_end)
                    begin
                        state_q <= OSTT_DONE; // R08
                    end
                end
                OSTT_DONE:
                begin
                    if (cnt_load)
                    begin
                        state_q <= OSTT_RUN; // R03
                    end
                end
                default:
                begin
                    state_q <= OSTT_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_o <= 1'b0;
            timer_clk_en_o <= 1'b0;
        end
        else
        begin
            // firmware clearing start in the cycle of expire masks the interrupt
            irq_o <= expire && !cnt_clear; // R13 R04
            timer_clk_en_o <= ctrl_q.enable && ctrl_q.start; // R10
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            current_tick_count_o <= OSTT_COUNT_RST[WIDTH-1:0];
            reload_value_o <= OSTT_RELOAD_RST[WIDTH-1:0];
        end
        else
        begin
            current_tick_count_o <= count;
            reload_value_o <= reload_q;
        end
    end

    // read answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bus_rdata_o <= 32'h0000_0000;
            bus_ack_o <= 1'b0;
        end
        else
        begin
            bus_ack_o <= bus_req_i.req;
            if (!rd_req)
            begin
                bus_rdata_o <= 32'h0000_0000;
            end
            else if (sel_count)
            begin
                bus_rdata_o <= 32'(count); // R12
            end
            else if (sel_reload)
            begin
                bus_rdata_o <= 32'(reload_q);
            end
            else if (sel_ctrl)
            begin
                bus_rdata_o <= {27'h000_0000, ctrl_q}; // R12
            end
            else
            begin
                bus_rdata_o <= 32'h0000_0000;
            end
        end
    end
endmodule

// >>> ostt_top_sva.sv
// checker: port-level assertions for the os tick timer control
`timescale 1ns/100ps
module ostt_top_sva
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // register port
    input wire ostt_pkg::ostt_bus_req_t bus_req_i,
    input wire logic [31:0] bus_rdata_o,
    input wire logic bus_ack_o,
    // timer side
    input wire logic ext_halt_i,
    input wire logic [WIDTH-1:0] current_tick_count_o,
    input wire logic [WIDTH-1:0] reload_value_o,
    input wire logic irq_o,
    input wire logic timer_clk_en_o
);
    import ostt_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence gated_s;
        !timer_clk_en_o [*4];
    endsequence
    sequence ctrl_read_s;
        bus_req_i.req && !bus_req_i.wr && bus_req_i.addr == OSTT_OFF_CTRL;
    endsequence
    ack_after_req_a: assert property (bus_req_i.req |=> bus_ack_o)
        else $error("ack missing after request");
    ack_cause_a: assert property (bus_ack_o |-> $past(bus_req_i.req))
        else $error("ack without request");
    rdata_idle_a: assert property (!bus_ack_o |-> bus_rdata_o == 32'h0)
        else $error("read data outside ack");
    ctrl_spare_a: assert property (ctrl_read_s |=> bus_rdata_o[31:5] == 27'h0)
        else $error("spare control bits read nonzero");
    irq_at_one_a: assert property (irq_o |-> current_tick_count_o == WIDTH'(1))
        else $error("interrupt not on step from one");
    irq_running_a: assert property (irq_o |-> $past(timer_clk_en_o))
        else $error("interrupt while timer stopped");
    gated_hold_a: assert property (gated_s |-> $stable(current_tick_count_o))
        else $error("count moved with clock gated");
    reload_write_a: assert property ($changed(reload_value_o) |-> $past(bus_req_i.req) || $past(bus_req_i.req, 2))
        else $error("reload value changed without write");
endmodule
bind ostt_top ostt_top_sva #(.WIDTH(WIDTH)) u_sva (.clock_i, .resetn_i, .bus_req_i, .bus_rdata_o, .bus_ack_o,
    .ext_halt_i, .current_tick_count_o, .reload_value_o, .irq_o, .timer_clk_en_o);

// >>> tb_top.sv
// testbench: directed scenarios for the os tick timer control
`timescale 1ns/100ps
module tb_top;
    import ostt_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    ostt_bus_req_t bus_req_i = '0;
    logic ext_halt_i = 1'b0;
    logic [31:0] bus_rdata_o, reload_value_o, current_tick_count_o, rd, prev, p;
    logic bus_ack_o, irq_o, timer_clk_en_o;
    int n_fail = 0;
    int n_compared = 0;
    int n_irq = 0;
    int g;
    always #5 clock_i = ~clock_i;
    always @(negedge clock_i) if (irq_o === 1'b1) n_irq++;
    ostt_top #(.WIDTH(32)) DUT (.clock_i, .resetn_i, .bus_req_i, .bus_rdata_o, .bus_ack_o, .ext_halt_i,
        .current_tick_count_o, .reload_value_o, .irq_o, .timer_clk_en_o);
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request is a one-cycle pulse, so it drops before the ack is polled
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(negedge clock_i);
        bus_req_i = '{1'b1, w, a, d};
        @(negedge clock_i);
        bus_req_i.req = 1'b0;
        for (k = 0; k < 3 && bus_ack_o !== 1'b1; k++) @(negedge clock_i);
        chk({31'h0, bus_ack_o}, 32'h1);
        rd = bus_rdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic cnt(input logic [31:0] e);
        chk(current_tick_count_o, e);
    endtask
    task automatic gap;
        g = 0;
        do
        begin
            @(negedge clock_i);
            g++;
        end
        while (irq_o !== 1'b1 && g < 20);
    endtask
    // loads may jump upward from one or zero, so only a step from above one is judged
    task automatic track(input int n);
        repeat (n)
        begin
            @(negedge clock_i);
            if (prev > 1 && current_tick_count_o !== prev)
                chk(current_tick_count_o, prev - 32'h1);
            prev = current_tick_count_o;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdc(OSTT_OFF_CTRL, 32'h0);
        wr(OSTT_OFF_RELOAD, 32'hdead_beef);
        rdc(OSTT_OFF_RELOAD, 32'hdead_beef);
        chk(reload_value_o, 32'hdead_beef);
        wr(OSTT_OFF_COUNT, 32'h1234_5678);
        rdc(OSTT_OFF_COUNT, 32'h0);
        rdc(8'h0c, 32'h0);
        wr(OSTT_OFF_CTRL, 32'hffff_ffe2);
        rdc(OSTT_OFF_CTRL, 32'h2);
        wr(OSTT_OFF_CTRL, 32'h4);
        cyc(4);
        cnt(32'h0);
        chk({31'h0, timer_clk_en_o}, 32'h0);
        wr(OSTT_OFF_CTRL, 32'h0);
    endtask
    task automatic t_oneshot;
        wr(OSTT_OFF_RELOAD, 32'h5);
        n_irq = 0;
        wr(OSTT_OFF_CTRL, 32'h5);
        cyc(1);
        cnt(32'h5);
        chk({31'h0, timer_clk_en_o}, 32'h1);
        prev = current_tick_count_o;
        track(10);
        chk(32'(n_irq), 32'h1);
        cnt(32'h0);
        rdc(OSTT_OFF_CTRL, 32'h1);
    endtask
    task automatic t_reload;
        wr(OSTT_OFF_RELOAD, 32'h3);
        n_irq = 0;
        wr(OSTT_OFF_CTRL, 32'h7);
        track(30);
        chk(32'(n_irq >= 9), 32'h1);
        rdc(OSTT_OFF_CTRL, 32'h7);
        wr(OSTT_OFF_RELOAD, 32'h6);
        gap;
        gap;
        chk(32'(g), 32'h6);
    endtask
    task automatic t_halt;
        wr(OSTT_OFF_RELOAD, 32'h40);
        wr(OSTT_OFF_CTRL, 32'h1);
        wr(OSTT_OFF_CTRL, 32'h5);
        wr(OSTT_OFF_CTRL, 32'h15);
        cyc(2);
        p = current_tick_count_o;
        cyc(6);
        cnt(p);
        rdc(OSTT_OFF_CTRL, 32'h15);
        ext_halt_i = 1'b1;
        wr(OSTT_OFF_CTRL, 32'hd);
        cyc(6);
        p = current_tick_count_o;
        cyc(6);
        cnt(p);
        wr(OSTT_OFF_CTRL, 32'h5);
        cyc(3);
        p = current_tick_count_o;
        cyc(3);
        cnt(p - 32'h3);
        ext_halt_i = 1'b0;
        wr(OSTT_OFF_CTRL, 32'hd);
        cyc(6);
        p = current_tick_count_o;
        cyc(2);
        cnt(p - 32'h2);
        n_irq = 0;
        wr(OSTT_OFF_CTRL, 32'h1);
        cyc(4);
        cnt(32'h0);
        chk(32'(n_irq), 32'h0);
    endtask
    task automatic t_zero;
        wr(OSTT_OFF_RELOAD, 32'h0);
        wr(OSTT_OFF_CTRL, 32'h5);
        rdc(OSTT_OFF_CTRL, 32'h1);
        wr(OSTT_OFF_RELOAD, 32'h4);
        wr(OSTT_OFF_CTRL, 32'h7);
        wr(OSTT_OFF_RELOAD, 32'h0);
        cyc(10);
        rdc(OSTT_OFF_CTRL, 32'h3);
        cnt(32'h0);
    endtask
    task automatic t_enoff;
        wr(OSTT_OFF_RELOAD, 32'h9);
        wr(OSTT_OFF_CTRL, 32'hf);
        cyc(3);
        wr(OSTT_OFF_CTRL, 32'h0);
        rdc(OSTT_OFF_RELOAD, 32'h0);
        rdc(OSTT_OFF_CTRL, 32'h0);
        cnt(32'h0);
        chk({31'h0, timer_clk_en_o}, 32'h0);
    endtask
    task automatic give_verdict;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        cyc(12);
        resetn_i = 1'b1;
        t_regs;
        t_oneshot;
        t_reload;
        t_halt;
        t_zero;
        t_enoff;
        give_verdict;
    end
    // run needs well under 1000 cycles
    initial
    begin
        #20000;
        n_fail++;
        give_verdict;
    end
endmodule
